// *** hdl/touch_acq_pkg.sv ***
/*
  Shared constants and carrier types for the touch acquisition and power
  scheduling block: register offsets, field positions, reset values, lookup
  figures and timing. Assumes a single 100 MHz clock.
*/
package touch_acq_pkg;

  // Register offsets, byte addressed
  localparam logic [7:0] OFS_DRIFT_BURST = 8'h16;
  localparam logic [7:0] OFS_HYST_SLEEP = 8'h19;
  localparam logic [7:0] OFS_HOLDOFF = 8'h1a;
  localparam logic [7:0] OFS_CHECK_LO = 8'hfe;
  localparam logic [7:0] OFS_CHECK_HI = 8'hff;
  localparam logic [7:0] OFS_STATUS = 8'h20;

  // Field positions
  localparam int BURST_LSB = 3;
  localparam int POSITIVE_DROPOUT_FRACTION_LSB = 6;
  localparam int NEGATIVE_DROPOUT_FRACTION_LSB = 4;
  localparam int WINSEL_BIT = 3;
  localparam int SLEEP_LSB = 0;

  // Reset values: wide entry window, sleep off, hold-off one unit
  localparam logic [7:0] RST_DRIFT_BURST = 8'h00;
  localparam logic [7:0] RST_HYST_SLEEP = 8'h08;
  localparam logic [7:0] RST_HOLDOFF = 8'h01;
  localparam logic [15:0] RST_CHECK = 16'h0000;

  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
  localparam logic [15:0] WINDOW_NARROW_MS = 16'd1000;
  localparam logic [15:0] WINDOW_WIDE_MS = 16'd10000;
  localparam logic [15:0] HOLDOFF_UNIT_MS = 16'd100;
  localparam logic [15:0] SLEEP_MS_1 = 16'd16;
  localparam logic [15:0] SLEEP_MS_2 = 16'd32;
  localparam logic [15:0] SLEEP_MS_3 = 16'd64;
  localparam logic [15:0] SLEEP_MS_4 = 16'd125;
  localparam logic [15:0] SLEEP_MS_5 = 16'd250;
  localparam logic [15:0] SLEEP_MS_6 = 16'd500;
  localparam logic [15:0] SLEEP_MS_7 = 16'd1000;

  // Register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;

  // Sense engine inputs, one set per sample
  typedef struct packed {
    logic signed [15:0] deviation;
    logic [7:0] pos_thr;
    logic [7:0] neg_thr;
    logic [7:0] positive_integrator_limit;
    logic [7:0] negative_integrator_limit;
  } sense_s;

  // Activity elsewhere that keeps the device awake, and the configuration mode exit
  typedef struct packed {
    logic config_mode_exit;
    logic pwm_active;
    logic rule_timer_running;
    logic calibrating;
  } activity_s;

  typedef enum logic [1:0] {
    ST_BURST,
    ST_DECIDE,
    ST_SLEEP
  } acq_state_e;

endpackage : touch_acq_pkg

// *** hdl/touch_acquisition_power_config.sv ***
/*
  Acquisition sequencer, detect declaration with hysteresis release, sleep
  scheduling, power-up configuration entry window and awake hold-off, with
  the configuration registers behind a plain byte-wide register port.
  Assumes all inputs come from logic on clk; read data follow one cycle
  after the read strobe.
*/
`timescale 1ns/1ns
`default_nettype none

module touch_acquisition_power_config #(
  parameter int unsigned TICK_CYCLES = touch_acq_pkg::MS_CYCLES
) (
  input wire logic clk,
  input wire logic resetn,
  input wire touch_acq_pkg::reg_req_s reg_req,
  output logic [7:0] rdata,
  input wire touch_acq_pkg::sense_s sense,
  input wire touch_acq_pkg::activity_s activity,
  input wire logic config_entry_req,
  output logic charge_transfer_pulse,
  output logic sample_done,
  output logic sleeping,
  output logic pos_detect,
  output logic neg_detect,
  output logic entry_window_open,
  output logic config_mode,
  output logic awake_active
);
  import touch_acq_pkg::*;

  // Burst length lookup
  function automatic logic [4:0] burst_pulses(input logic [1:0] idx);
    burst_pulses = 5'h02 << idx;
  endfunction : burst_pulses

  // Release point: threshold less a power-of-two fraction of itself
  function automatic logic [7:0] dropout(input logic [7:0] thr,
                                         input logic [1:0] idx);
    dropout = thr - (thr >> (3'd4 - {1'b0, idx}));
  endfunction : dropout

  // Sleep interval lookup in milliseconds
  function automatic logic [15:0] sleep_ms(input logic [2:0] idx);
    case (idx)
      3'h1: sleep_ms = SLEEP_MS_1;
      3'h2: sleep_ms = SLEEP_MS_2;
      3'h3: sleep_ms = SLEEP_MS_3;
      3'h4: sleep_ms = SLEEP_MS_4;
      3'h5: sleep_ms = SLEEP_MS_5;
      3'h6: sleep_ms = SLEEP_MS_6;
      3'h7: sleep_ms = SLEEP_MS_7;
      default: sleep_ms = 16'h0000;
    endcase
  endfunction : sleep_ms

  logic [7:0] drift_and_burst_config_q;
  logic [7:0] hysteresis_window_sleep_config_q;
  logic [7:0] post_detect_holdoff_q;
  logic [15:0] config_check_value_q;
  logic [7:0] rdata_q;
  logic [31:0] tick_cnt_q;
  logic tick_q;
  acq_state_e state_q;
  logic [4:0] pulses_left_q;
  logic pulse_q;
  logic done_q;
  logic sleeping_q;
  logic [15:0] sleep_left_q;
  logic pos_det_q;
  logic neg_det_q;
  logic [7:0] pos_di_q;
  logic [7:0] neg_di_q;
  logic [15:0] window_ms_q;
  logic window_q;
  logic cfg_mode_q;
  logic [15:0] holdoff_left_q;
  logic awake_q;

  logic [1:0] pulse_count_index;
  logic [1:0] positive_dropout_fraction;
  logic [1:0] negative_dropout_fraction;
  logic config_entry_window_select;
  logic [2:0] sleep_index;
  logic signed [16:0] dev_p;
  logic signed [16:0] dev_n;
  logic pos_over;
  logic neg_over;
  logic pos_release;
  logic neg_release;
  logic detect_end;
  logic sleep_block;
  logic sleep_ok;
  logic [15:0] window_len_ms;

  // Field extraction
  assign pulse_count_index = drift_and_burst_config_q[BURST_LSB +: 2];
  assign positive_dropout_fraction =
    hysteresis_window_sleep_config_q[POSITIVE_DROPOUT_FRACTION_LSB +: 2];
  assign negative_dropout_fraction =
    hysteresis_window_sleep_config_q[NEGATIVE_DROPOUT_FRACTION_LSB +: 2];
  assign config_entry_window_select =
    hysteresis_window_sleep_config_q[WINSEL_BIT];
  assign sleep_index = hysteresis_window_sleep_config_q[SLEEP_LSB +: 3];

  // Register writes; the check value is kept as written, never used
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      drift_and_burst_config_q <= RST_DRIFT_BURST;
      hysteresis_window_sleep_config_q <= RST_HYST_SLEEP;
      post_detect_holdoff_q <= RST_HOLDOFF;
      config_check_value_q <= RST_CHECK;
    end else if (reg_req.wr) begin
      case (reg_req.addr)
        OFS_DRIFT_BURST: drift_and_burst_config_q <= reg_req.wdata;
        OFS_HYST_SLEEP: hysteresis_window_sleep_config_q <= reg_req.wdata;
        OFS_HOLDOFF: post_detect_holdoff_q <= reg_req.wdata;
        OFS_CHECK_LO: config_check_value_q[7:0] <= reg_req.wdata;
        OFS_CHECK_HI: config_check_value_q[15:8] <= reg_req.wdata;
        default: ;
      endcase
    end
  end

  // Read data for one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= 8'h00;
    end else if (reg_req.rd) begin
      case (reg_req.addr)
        OFS_DRIFT_BURST: rdata_q <= drift_and_burst_config_q;
        OFS_HYST_SLEEP: rdata_q <= hysteresis_window_sleep_config_q;
        OFS_HOLDOFF: rdata_q <= post_detect_holdoff_q;
        OFS_CHECK_LO: rdata_q <= config_check_value_q[7:0];
        OFS_CHECK_HI: rdata_q <= config_check_value_q[15:8];
        OFS_STATUS: rdata_q <= {1'b0, awake_q, cfg_mode_q, window_q,
                                neg_det_q, pos_det_q, sleeping_q, sleep_ok};
        default: rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end

  // Millisecond tick shared by every long timer
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tick_cnt_q <= 32'h0000_0000;
      tick_q <= 1'b0;
    end else if (tick_cnt_q >= TICK_CYCLES - 1) begin
      tick_cnt_q <= 32'h0000_0000;
      tick_q <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
      tick_q <= 1'b0;
    end
  end

  // Threshold crossing and release tests on the current deviation
  assign dev_p = {sense.deviation[15], sense.deviation};
  assign dev_n = -dev_p;
  assign pos_over = dev_p > $signed({9'h000, sense.pos_thr});
  assign neg_over = dev_n > $signed({9'h000, sense.neg_thr});
  assign pos_release = pos_det_q && (dev_p <
    $signed({9'h000, dropout(sense.pos_thr, positive_dropout_fraction)}));
  assign neg_release = neg_det_q && (dev_n <
    $signed({9'h000, dropout(sense.neg_thr, negative_dropout_fraction)}));
  assign detect_end = done_q && (pos_release || neg_release);

  // Positive detect: count agreeing samples, then release via hysteresis
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pos_det_q <= 1'b0;
      pos_di_q <= 8'h00;
    end else if (done_q) begin
      if (pos_det_q) begin
        if (pos_release) begin
          pos_det_q <= 1'b0;
          pos_di_q <= 8'h00;
        end
      end else if (pos_over) begin
        if (pos_di_q + 8'h01 >= sense.positive_integrator_limit) begin
          pos_det_q <= 1'b1;
        end
        if (pos_di_q != 8'hff) begin
          pos_di_q <= pos_di_q + 8'h01;
        end
      end else begin
        pos_di_q <= 8'h00;
      end
    end
  end

  // Negative detect mirrors the positive side
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      neg_det_q <= 1'b0;
      neg_di_q <= 8'h00;
    end else if (done_q) begin
      if (neg_det_q) begin
        if (neg_release) begin
          neg_det_q <= 1'b0;
          neg_di_q <= 8'h00;
        end
      end else if (neg_over) begin
        if (neg_di_q + 8'h01 >= sense.negative_integrator_limit) begin
          neg_det_q <= 1'b1;
        end
        if (neg_di_q != 8'hff) begin
          neg_di_q <= neg_di_q + 8'h01;
        end
      end else begin
        neg_di_q <= 8'h00;
      end
    end
  end

  // Power-up entry window; its length follows the select bit live
  assign window_len_ms = config_entry_window_select ?
                         WINDOW_WIDE_MS : WINDOW_NARROW_MS;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      window_ms_q <= 16'h0000;
      window_q <= 1'b1;
    end else if (window_q && tick_q) begin
      window_ms_q <= window_ms_q + 16'h0001;
      if (window_ms_q + 16'h0001 >= window_len_ms) begin
        window_q <= 1'b0;
      end
    end
  end

  // Configuration mode may only be entered while the window is open
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cfg_mode_q <= 1'b0;
    end else if (config_entry_req && window_q) begin
      cfg_mode_q <= 1'b1;
    end else if (activity.config_mode_exit) begin
      cfg_mode_q <= 1'b0;
    end
  end

  // Hold-off reloads on every detect end, only while sleep is enabled
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      holdoff_left_q <= 16'h0000;
    end else if (sleep_index == 3'h0) begin
      holdoff_left_q <= 16'h0000;
    end else if (detect_end) begin
      holdoff_left_q <= 16'(post_detect_holdoff_q * HOLDOFF_UNIT_MS);
    end else if (tick_q && holdoff_left_q != 16'h0000) begin
      holdoff_left_q <= holdoff_left_q - 16'h0001;
    end
  end

  // Awake flag registered from the counter, as seen by the scheduler
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      awake_q <= 1'b0;
    end else begin
      awake_q <= holdoff_left_q != 16'h0000;
    end
  end

  // Anything that keeps the device sampling continuously
  assign sleep_block = cfg_mode_q || window_q || activity.pwm_active ||
                       activity.rule_timer_running || awake_q;
  assign sleep_ok = (sleep_index != 3'h0) && !sleep_block &&
                    !activity.calibrating && !pos_det_q && !neg_det_q &&
                    !pos_over && !neg_over;

  // Sequencer: burst, then one cycle to let detects settle, then sleep
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= ST_BURST;
      pulses_left_q <= 5'h02;
      pulse_q <= 1'b0;
      done_q <= 1'b0;
      sleeping_q <= 1'b0;
      sleep_left_q <= 16'h0000;
    end else begin
      done_q <= 1'b0;
      case (state_q)
        ST_BURST: begin
          if (!pulse_q) begin
            pulse_q <= 1'b1;
          end else begin
            pulse_q <= 1'b0;
            if (pulses_left_q <= 5'h01) begin
              done_q <= 1'b1;
              state_q <= ST_DECIDE;
            end else begin
              pulses_left_q <= pulses_left_q - 5'h01;
            end
          end
        end
        ST_DECIDE: begin
          // Pulse count latched here so a mid-burst write waits a sample
          pulses_left_q <= burst_pulses(pulse_count_index);
          if (sleep_ok) begin
            sleep_left_q <= sleep_ms(sleep_index);
            sleeping_q <= 1'b1;
            state_q <= ST_SLEEP;
          end else begin
            state_q <= ST_BURST;
          end
        end
        ST_SLEEP: begin
          // The wait falls short by at most one tick of tick phase
          if (tick_q) begin
            if (sleep_left_q <= 16'h0001) begin
              sleeping_q <= 1'b0;
              state_q <= ST_BURST;
            end else begin
              sleep_left_q <= sleep_left_q - 16'h0001;
            end
          end
        end
        default: begin
          state_q <= ST_BURST;
          sleeping_q <= 1'b0;
        end
      endcase
    end
  end

  assign rdata = rdata_q;
  assign charge_transfer_pulse = pulse_q;
  assign sample_done = done_q;
  assign sleeping = sleeping_q;
  assign pos_detect = pos_det_q;
  assign neg_detect = neg_det_q;
  assign entry_window_open = window_q;
  assign config_mode = cfg_mode_q;
  assign awake_active = awake_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // Helper: pulses seen since the last sample
  logic [5:0] seen_q;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      seen_q <= 6'h00;
    end else if (done_q) begin
      seen_q <= 6'h00;
    end else if (pulse_q && !$past(pulse_q)) begin
      seen_q <= seen_q + 6'h01;
    end
  end

  // Helper: burst length promised by the index at the last decide cycle
  logic [5:0] exp_pulses_q;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      exp_pulses_q <= 6'h02;
    end else if (state_q == ST_DECIDE) begin
      exp_pulses_q <= 6'h02 << pulse_count_index;
    end
  end

  sequence burst_end_s;
    pulse_q ##1 !pulse_q && done_q;
  endsequence

  sequence decide_s;
    state_q == ST_DECIDE && sleep_ok;
  endsequence

  burst_pulses_a: assert property (
    $rose(done_q) |-> seen_q == exp_pulses_q
  ) else $error("burst pulse count wrong");

  burst_ends_a: assert property (
    state_q == ST_BURST && pulse_q && pulses_left_q == 5'h01 |=>
    !pulse_q && done_q && state_q == ST_DECIDE ##1 !done_q
  ) else $error("burst did not end in a sample");

  sleep_never_a: assert property (
    sleep_index == 3'h0 && state_q == ST_DECIDE |=> !sleeping_q
  ) else $error("slept with sleep disabled");

  sleep_block_a: assert property (
    state_q == ST_DECIDE && (window_q || cfg_mode_q || awake_q ||
    pos_det_q || neg_det_q || activity.calibrating) |=> !sleeping_q
  ) else $error("slept while blocked");

  sleep_len_a: assert property (
    decide_s and sleep_index == 3'h1 |=> sleep_left_q == 16'h0010
  ) else $error("sleep interval wrong");

  window_entry_a: assert property (
    !window_q && !cfg_mode_q && !activity.config_mode_exit |=> !cfg_mode_q
  ) else $error("config mode entered outside window");

  window_reset_a: assert property (
    $rose(resetn) |-> config_entry_window_select && window_q
  ) else $error("entry window reset state wrong");

  holdoff_load_a: assert property (
    detect_end && sleep_index != 3'h0 |=>
    holdoff_left_q == 16'(post_detect_holdoff_q * HOLDOFF_UNIT_MS)
    ##1 awake_q || post_detect_holdoff_q == 8'h00
  ) else $error("hold-off not loaded on detect end");

  holdoff_off_a: assert property (
    sleep_index == 3'h0 |=> holdoff_left_q == 16'h0000
  ) else $error("hold-off active with sleep off");

  release_hyst_a: assert property (
    done_q && pos_det_q && dev_p >= $signed({9'h000, sense.pos_thr}) |=>
    pos_det_q
  ) else $error("detect released above threshold");

  declare_a: assert property (
    burst_end_s ##0 (!pos_det_q && !pos_over) |=> !pos_det_q
  ) else $error("detect declared without crossing");

endmodule : touch_acquisition_power_config
`default_nettype wire

// *** bench/sense_electrode.sv ***
/*
  Behavioural sense electrode with an object nearby: turns each burst of
  charge-transfer pulses into a signed deviation reading.
  Assumes the block's clock, its pulse pin and its sleep flag.
*/
`timescale 1ns/1ns
`default_nettype none
module sense_electrode (
  input wire logic clk,
  input wire logic resetn,
  input wire logic charge_transfer_pulse,
  input wire logic sleeping,
  input wire logic signed [15:0] object_dev,
  output logic signed [15:0] deviation
);
  // A reading only forms while charge is moved; asleep nothing drives the
  // electrode, so a toggling junk value is shown instead of the last one
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      deviation <= 16'sh0000;
    end else if (charge_transfer_pulse) begin
      deviation <= object_dev;
    end else if (sleeping) begin
      deviation <= ~deviation;
    end
  end
endmodule : sense_electrode
`default_nettype wire

// *** bench/touch_acquisition_power_config_test.sv ***
/*
  Self-checking bench for the touch acquisition and power block:
  registers, bursts, detect and release, entry window, sleep, hold-off.
  Assumes TICK_CYCLES cut to 2, so a millisecond is two clocks.
*/
`timescale 1ns/1ns
`default_nettype none
module touch_acquisition_power_config_test;
  import touch_acq_pkg::*;
  localparam int T = 2;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  reg_req_s req = '0;
  activity_s act = '0;
  logic entry_req = 1'b0;
  logic signed [15:0] obj_dev = 16'sh0000;
  logic signed [15:0] dev;
  sense_s sense;
  logic [7:0] rdata;
  logic pulse, done, sleeping, pdet, ndet, win, cfg, awake;
  int n_mismatch = 0;
  int cmp_count = 0;
  int cyc = 0;
  int win_sleep = 0;
  int aw_sleep = 0;
  int ms[8] = '{0, 16, 32, 64, 125, 250, 500, 1000};
  int bl[4] = '{2, 4, 8, 16};

  // Thresholds 64, integrator limits 2
  assign sense = {dev, 8'h40, 8'h40, 8'h02, 8'h02};

  touch_acquisition_power_config #(.TICK_CYCLES(T))
    u_touch_acquisition_power_config (
    .clk(clk), .resetn(resetn), .reg_req(req), .rdata(rdata),
    .sense(sense), .activity(act), .config_entry_req(entry_req),
    .charge_transfer_pulse(pulse), .sample_done(done),
    .sleeping(sleeping), .pos_detect(pdet), .neg_detect(ndet),
    .entry_window_open(win), .config_mode(cfg), .awake_active(awake));

  sense_electrode u_sense_electrode (
    .clk(clk), .resetn(resetn), .charge_transfer_pulse(pulse),
    .sleeping(sleeping), .object_dev(obj_dev), .deviation(dev));

  // Clock
  initial begin
    forever #5 clk = ~clk;
  end

  // Cycle count and sleeps that must never happen
  always @(posedge clk) begin
    if (resetn) cyc <= cyc + 1;
    if (win && sleeping) win_sleep <= win_sleep + 1;
    if (awake && sleeping) aw_sleep <= aw_sleep + 1;
  end

  task chk(input string what, input logic [15:0] exp, got);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s exp %0h got %0h", what, exp, got);
    end
  endtask : chk

  task chk_rng(input string what, input int lo, hi, got);
    cmp_count++;
    if (got < lo || got > hi) begin
      n_mismatch++;
      $display("mismatch %s exp %0d..%0d got %0d", what, lo, hi, got);
    end
  endtask : chk_rng

  task wr(input logic [7:0] a, d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task rd(input logic [7:0] a, exp);
    @(posedge clk);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    #1;
    chk("rdata", {8'h00, exp}, {8'h00, rdata});
  endtask : rd

  // Bounded wait for the end of a sample
  task wait_done();
    int k;
    k = 0;
    do begin
      @(posedge clk);
      #1;
      k++;
    end while (done !== 1'b1 && k < 5000);
    if (k >= 5000) chk("sample_done", 16'h0001, 16'h0000);
  endtask : wait_done

  // Object level applies from the next whole sample on
  task feed(input int v, n);
    wait_done();
    obj_dev <= 16'(v);
    repeat (n) wait_done();
    repeat (2) @(posedge clk);
    #1;
  endtask : feed

  task count_burst(output int n);
    n = 0;
    wait_done();
    do begin
      @(posedge clk);
      #1;
      if (pulse === 1'b1) n++;
    end while (done !== 1'b1 && n < 40);
  endtask : count_burst

  // Waits for a level to rise, then counts how long it stays high
  task automatic high_len(ref logic s, input int bound, output int n);
    int k;
    k = 0;
    n = 0;
    while (s !== 1'b1 && k < bound) begin
      @(posedge clk);
      #1;
      k++;
    end
    while (s === 1'b1 && n < 5000) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask : high_len

  task final_report();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report

  // Watchdog well past the expected run of some 14000 cycles
  initial begin
    #400000;
    n_mismatch++;
    final_report();
  end

  initial begin
    int n, v, amp, rel;
    logic [15:0] cv;
    void'($urandom(5167));
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    rd(OFS_DRIFT_BURST, 8'h00);
    rd(OFS_HYST_SLEEP, 8'h08);
    rd(OFS_HOLDOFF, 8'h01);
    rd(OFS_CHECK_LO, 8'h00);
    rd(8'h30, 8'h00);
    rd(OFS_STATUS, 8'h10);
    wr(OFS_HYST_SLEEP, 8'h01);
    entry_req <= 1'b1;
    @(posedge clk);
    entry_req <= 1'b0;
    #1;
    chk("config_mode", 16'h0001, {15'h0, cfg});
    act.config_mode_exit <= 1'b1;
    @(posedge clk);
    act.config_mode_exit <= 1'b0;
    @(posedge clk);
    #1;
    chk("config_mode", 16'h0000, {15'h0, cfg});
    for (int i = 0; i < 4; i++) begin
      wr(OFS_DRIFT_BURST, 8'(i << 3) | (8'($urandom) & 8'he7));
      count_burst(n);
      chk("pulses", 16'(bl[i]), 16'(n));
    end
    wr(OFS_DRIFT_BURST, 8'($urandom) & 8'he7);
    cv = 16'($urandom);
    wr(OFS_CHECK_LO, cv[7:0]);
    wr(OFS_CHECK_HI, cv[15:8]);
    rd(OFS_CHECK_LO, cv[7:0]);
    rd(OFS_CHECK_HI, cv[15:8]);
    for (int i = 0; i < 4; i++) begin
      wr(OFS_HYST_SLEEP, 8'((i << 6) | (i << 4) | 1));
      // Release point: a 64 threshold less 6.25 percent of it, doubled per index
      rel = 64 - (4 << i);
      for (int s = 0; s < 2; s++) begin
        v = s ? -1 : 1;
        amp = 65 + $urandom % 136;
        feed(0, 1);
        feed(v * amp, 1);
        chk("one crossing", 16'h0000, {15'h0, s ? ndet : pdet});
        feed(v * amp, 1);
        chk("declared", 16'h0001, {15'h0, s ? ndet : pdet});
        feed(v * rel, 1);
        chk("held", 16'h0001, {15'h0, s ? ndet : pdet});
        feed(v * (rel - 1), 1);
        chk("released", 16'h0000, {15'h0, s ? ndet : pdet});
      end
    end
    wait (cyc >= 1995);
    #1;
    chk("window", 16'h0001, {15'h0, win});
    wait (cyc >= 2010);
    #1;
    chk("window", 16'h0000, {15'h0, win});
    chk("sleep in window", 16'h0000, 16'(win_sleep));
    entry_req <= 1'b1;
    @(posedge clk);
    entry_req <= 1'b0;
    #1;
    chk("late entry", 16'h0000, {15'h0, cfg});
    for (int i = 1; i < 8; i++) begin
      wr(OFS_HYST_SLEEP, 8'(i));
      high_len(sleeping, 3000, n);
      high_len(sleeping, 3000, n);
      chk_rng("sleep len", ms[i] * T - T, ms[i] * T + 4, n);
    end
    wr(OFS_HYST_SLEEP, 8'h00);
    high_len(sleeping, 2100, n);
    high_len(sleeping, 300, n);
    chk("sleep off", 16'h0000, 16'(n));
    wr(OFS_HYST_SLEEP, 8'h01);
    // Each blocker replaces the last in one step, but the object level blocks only after a burst reads it, so one sleep gets in there
    for (int b = 0; b < 4; b++) begin
      act.pwm_active <= (b == 0);
      act.rule_timer_running <= (b == 1);
      act.calibrating <= (b == 2);
      obj_dev <= (b == 3) ? 16'sh0064 : 16'sh0000;
      repeat (60) @(posedge clk);
      high_len(sleeping, 150, n);
      chk("blocked", 16'h0000, 16'(n));
    end
    act <= '0;
    obj_dev <= 16'sh0000;
    for (int s = 0; s < 2; s++) begin
      v = 1 + $urandom % 3;
      wr(OFS_HOLDOFF, 8'(v));
      wr(OFS_HYST_SLEEP, 8'(1 - s));
      feed(100, 2);
      feed(0, 1);
      high_len(awake, 20, n);
      if (s == 0) chk_rng("holdoff", v * 200 - 6, v * 200 + 4, n);
      else chk("holdoff off", 16'h0000, 16'(n));
    end
    chk("sleep in holdoff", 16'h0000, 16'(aw_sleep));
    final_report();
  end
endmodule : touch_acquisition_power_config_test
`default_nettype wire
